// ===== inc/rpi_pkg.sv
// package for the raster processor plane interface
// assumes a 24-bit word address from the raster processor, four planes
package rpi_pkg;
  // ======================================================================
  // address map
  localparam int ADDR_W = 24;
  localparam int NUM_PLANES = 4;
  localparam int WORD_W = 16;
  localparam logic [23:0] ROM_BASE = 24'h00_0000;
  localparam logic [23:0] ROM_LAST = 24'h3F_FFFF;
  localparam logic [23:0] PLANE_BASE = 24'h40_0000;
  localparam logic [23:0] PLANE_LAST = 24'h43_FFFF;
  localparam int PLANE_SEL_LSB = 16;
  localparam logic [23:0] CTRL_REG_ADDR = 24'h80_0001;
  localparam logic [23:0] PIX_LOAD_ADDR = 24'h80_0002;
  localparam logic [23:0] PIX_OUT_ADDR = 24'h80_0004;
  localparam logic [23:0] FSEL_BASE = 24'hA0_0000;
  localparam logic [23:0] FSEL_ALL_ADDR = 24'hA0_000F;
  localparam logic [23:0] UART_BASE = 24'hC0_0000;
  localparam logic [23:0] UART_LAST = 24'hDF_FFFF;
  localparam logic [23:0] PCTL_BASE = 24'hE0_0000;
  // ======================================================================
  // memory timing at 20 MHz, period 50 ns
  localparam int CLK_NS = 50;
  localparam int RAS_LOW_NS = 120;
  localparam int RAS_PRE_NS = 90;
  localparam int CAS_LOW_NS = 60;
  localparam logic [2:0] RAS_LOW_CYC = 3'((RAS_LOW_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [2:0] RAS_PRE_CYC = 3'((RAS_PRE_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [2:0] CAS_LOW_CYC = 3'((CAS_LOW_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [3:0] PLANE_EN_RST = 4'h0;

  // decoded chip selects
  typedef struct packed {
    logic rom_en;
    logic [3:0] plane_hit;
    logic ctrl_reg_load_strobe;
    logic pix_load;
    logic pix_out;
    logic [3:0] func_select_load_strobe;
    logic uart_en;
    logic pctl_load;
  } rpi_sel_t;

  // request from the raster processor
  typedef struct packed {
    logic [23:0] addr;
    logic wr;
    logic drawing;
    logic src_read;
  } rpi_req_t;
endpackage : rpi_pkg

// ===== rtl/rpi_decoder.sv
// address decoder: makes chip selects from the processor address
// assumes addr is stable while io_en is high
`timescale 1ns/1ps
module rpi_decoder (
  input wire logic [23:0] addr_i,
  input wire logic io_en_i,
  output rpi_pkg::rpi_sel_t sel_o
);
  import rpi_pkg::*;
  // ======================================================================
  // combinational decode; every select but plane_hit is timed by the linear access strobe
  always_comb begin
    sel_o = '0;
    sel_o.rom_en = (addr_i <= ROM_LAST);
    if (addr_i >= PLANE_BASE && addr_i <= PLANE_LAST) begin
      sel_o.plane_hit[addr_i[PLANE_SEL_LSB+1:PLANE_SEL_LSB]] = 1'b1;
    end
    sel_o.ctrl_reg_load_strobe = io_en_i && (addr_i == CTRL_REG_ADDR);
    sel_o.pix_load = io_en_i && (addr_i == PIX_LOAD_ADDR);
    sel_o.pix_out = io_en_i && (addr_i == PIX_OUT_ADDR);
    // each low bit picks a plane, so 0xF loads all four together
    if (io_en_i && addr_i[23:4] == FSEL_BASE[23:4] && addr_i[3:0] != 4'h0) begin
      sel_o.func_select_load_strobe = addr_i[3:0];
    end
    sel_o.uart_en = io_en_i && addr_i >= UART_BASE && addr_i <= UART_LAST;
    sel_o.pctl_load = io_en_i && addr_i >= PCTL_BASE;
    sel_o.rom_en = sel_o.rom_en && io_en_i;
  end
endmodule : rpi_decoder

// ===== rtl/rpi_plane_interface.sv
// raster processor to plane memory glue: bus sequencer, plane controller, decoder
// assumes the processor holds its request until ready is returned
`timescale 1ns/1ps
module rpi_plane_interface (
  input wire logic sys_clk_i,
  input wire logic sys_rst_i,
  input wire rpi_pkg::rpi_req_t req_i,
  input wire logic req_valid_i,
  input wire logic [15:0] cpu_data_i,
  input wire logic [3:0] src_plane_i,
  output logic ready_o,
  output logic ras_n_o,
  output logic row_col_o,
  output logic [3:0] cas_n_o,
  output logic wr_n_o,
  output logic oe_n_o,
  output logic xcv_dir_in_o,
  output logic xcv_en_n_o,
  output logic [3:0] plane_xcv_en_n_o,
  output logic io_en_o,
  output rpi_pkg::rpi_sel_t sel_o,
  output logic [3:0] plane_en_o
);
  import rpi_pkg::*;

  typedef enum logic [4:0] {
    S_IDLE = 5'b0_0001,
    S_RAS = 5'b0_0010,
    S_CAS = 5'b0_0100,
    S_PRE = 5'b0_1000,
    S_IO = 5'b1_0000
  } rpi_state_t;

  rpi_state_t state_ff;
  rpi_state_t nxt_state;
  logic [2:0] cnt_ff;
  logic [2:0] nxt_cnt;
  rpi_req_t req_ff;
  rpi_req_t req_cur;
  logic [3:0] plane_en_ff;
  rpi_sel_t sel_now;
  logic is_mem;
  logic io_en;

  function automatic logic cnt_done(input logic [2:0] c);
    cnt_done = (c <= 3'd1);
  endfunction : cnt_done

  // ======================================================================
  // bus sequencer: plane memory gets ras/cas, everything else a linear strobe
  assign is_mem = (req_i.addr >= PLANE_BASE && req_i.addr <= PLANE_LAST) || req_i.drawing;
  always_comb begin
    nxt_state = state_ff;
    nxt_cnt = cnt_ff;
    case (state_ff)
      S_IDLE: begin
        if (req_valid_i) begin
          nxt_state = is_mem ? S_RAS : S_IO;
          nxt_cnt = RAS_LOW_CYC - CAS_LOW_CYC;
        end
      end
      S_RAS: begin
        if (cnt_done(cnt_ff)) begin
          nxt_state = S_CAS;
          nxt_cnt = CAS_LOW_CYC;
        end else begin
          nxt_cnt = cnt_ff - 3'd1;
        end
      end
      S_CAS: begin
        if (cnt_done(cnt_ff)) begin
          nxt_state = S_PRE;
          nxt_cnt = RAS_PRE_CYC;
        end else begin
          nxt_cnt = cnt_ff - 3'd1;
        end
      end
      S_PRE: begin
        if (cnt_done(cnt_ff)) begin
          nxt_state = S_IDLE;
        end else begin
          nxt_cnt = cnt_ff - 3'd1;
        end
      end
      S_IO: nxt_state = S_IDLE;
      default: nxt_state = S_IDLE;
    endcase
  end

  // state and counter
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      state_ff <= S_IDLE;
      cnt_ff <= 3'd0;
    end else begin
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt;
    end
  end

  // request captured as it is taken, so decode stays stable during the access
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      req_ff <= '0;
    end else if (state_ff == S_IDLE && req_valid_i) begin
      req_ff <= req_i;
    end
  end

  // ======================================================================
  // at the take edge req_ff still holds the previous request, so the one-cycle
  // linear strobes are decoded from the incoming request instead
  assign req_cur = (state_ff == S_IDLE) ? req_i : req_ff;

  // strobes from state; registered for clean edges on the memory pins
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      ras_n_o <= 1'b1;
      row_col_o <= 1'b0;
      cas_n_o <= 4'hF;
      wr_n_o <= 1'b1;
      oe_n_o <= 1'b1;
      xcv_dir_in_o <= 1'b0;
      xcv_en_n_o <= 1'b1;
      plane_xcv_en_n_o <= 4'hF;
    end else begin
      ras_n_o <= !(nxt_state == S_RAS || nxt_state == S_CAS);
      row_col_o <= (nxt_state == S_CAS);
      cas_n_o <= (nxt_state == S_CAS) ? ~plane_mask(req_ff) : 4'hF;
      wr_n_o <= !((nxt_state == S_CAS || nxt_state == S_IO) && req_cur.wr);
      oe_n_o <= !((nxt_state == S_CAS || nxt_state == S_IO) && !req_cur.wr);
      // drawing data never reaches the processor bus: cut the transceiver
      xcv_en_n_o <= !((nxt_state == S_CAS || nxt_state == S_IO) && !req_cur.drawing);
      xcv_dir_in_o <= !req_cur.wr;
      // source plane drives the common bus only on an interplane source read
      plane_xcv_en_n_o <= (nxt_state == S_CAS && req_ff.drawing && req_ff.src_read) ?
        ~src_plane_i : 4'hF;
    end
  end

  // planes taking part: linear access hits one plane, drawing uses the latch, a source read uses src_plane_i
  function automatic logic [3:0] plane_mask(input rpi_req_t r);
    logic [3:0] m;
    m = 4'h0;
    if (r.drawing) begin
      m = plane_en_ff;
      if (r.src_read) begin
        m = src_plane_i;
      end
    end else begin
      m[r.addr[PLANE_SEL_LSB+1:PLANE_SEL_LSB]] = 1'b1;
    end
    plane_mask = m;
  endfunction : plane_mask

  assign io_en = (state_ff == S_IO);
  assign io_en_o = io_en;
  assign ready_o = (state_ff == S_IO) || (state_ff == S_PRE && cnt_done(cnt_ff));

  // ======================================================================
  // decoder and plane select latch
  rpi_decoder u_dec (
    .addr_i(req_ff.addr),
    .io_en_i(io_en),
    .sel_o(sel_now)
  );
  assign sel_o = sel_now;

  // the control and pixel port strobes go to the manipulators, which do the
  // bit capture and replication themselves
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      plane_en_ff <= PLANE_EN_RST;
    end else if (sel_now.pctl_load && req_ff.wr) begin
      plane_en_ff <= cpu_data_i[3:0];
    end
  end
  assign plane_en_o = plane_en_ff;

  // ======================================================================
  // checks
  sequence mem_start_s;
    state_ff == S_IDLE && req_valid_i && is_mem;
  endsequence
  ras_after_take_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    mem_start_s |=> !ras_n_o) else $error("ras not low after take");
  ras_width_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    $fell(ras_n_o) |-> !ras_n_o [*3]) else $error("ras too short");
  ras_pre_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    $rose(ras_n_o) |-> ras_n_o [*2]) else $error("ras precharge short");
  rom_zero_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    (io_en && req_ff.addr == ROM_BASE) |-> sel_now.rom_en) else $error("rom at zero");
  ctrl_strobe_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    sel_now.ctrl_reg_load_strobe |-> io_en && req_ff.addr == CTRL_REG_ADDR)
    else $error("control strobe bad");
  fsel_all_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    (io_en && req_ff.addr == FSEL_ALL_ADDR) |-> sel_now.func_select_load_strobe == 4'hF)
    else $error("all select bad");
  fsel_one_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    $onehot(sel_now.func_select_load_strobe) |-> io_en && !req_ff.drawing)
    else $error("select outside linear");
  plane_hit_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    (req_ff.addr >= PLANE_BASE && req_ff.addr <= PLANE_LAST) |-> $onehot(sel_now.plane_hit))
    else $error("plane decode bad");
  draw_cut_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    (state_ff == S_CAS && req_ff.drawing) |=> xcv_en_n_o) else $error("drawing on cpu bus");
  ready_bound_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
    mem_start_s |-> ##[1:8] ready_o) else $error("no ready");
endmodule : rpi_plane_interface

// ===== sim/rpi_plane_mem_model.sv
// plane memory model: counts the strobe cycles each plane's dram sees
// assumes it shares the interface clock; it holds no data, only watches strobes
`timescale 1ns/1ps
module rpi_plane_mem_model (
  input wire logic sys_clk_i,
  input wire logic ras_n_i,
  input wire logic [3:0] cas_n_i,
  output logic [7:0] ras_cnt_o = 8'h00,
  output logic [3:0][7:0] cas_cnt_o = '0
);
  // ======================================================================
  // strobe counters
  // sampled on the rising edge as the dram would latch them; counts wrap,
  // so only differences across one access mean anything
  always @(posedge sys_clk_i) begin
    if (ras_n_i === 1'b0) ras_cnt_o <= ras_cnt_o + 8'h01;
    for (int p = 0; p < 4; p++) begin
      if (cas_n_i[p] === 1'b0) cas_cnt_o[p] <= cas_cnt_o[p] + 8'h01;
    end
  end
endmodule : rpi_plane_mem_model

// ===== sim/raster_processor_plane_interface_test.sv
// testbench for the raster processor plane interface
// assumes the design's package is compiled first and one 20 MHz clock
`timescale 1ns/1ps
module raster_processor_plane_interface_test;
  import rpi_pkg::*;
  typedef struct packed {
    logic [23:0] addr;
    logic wr;
    logic [15:0] dat;
    logic [13:0] sel;
    logic [3:0] cas;
  } rpi_row_t;
  logic sys_clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  rpi_req_t req_i = '0;
  logic req_valid_i = 1'b0;
  logic [15:0] cpu_data_i = 16'h0000;
  logic [3:0] src_plane_i = 4'h0;
  logic ready_o, ras_n_o, row_col_o, wr_n_o, oe_n_o, xcv_dir_in_o, xcv_en_n_o, io_en_o;
  logic [3:0] cas_n_o, plane_xcv_en_n_o, plane_en_o, cas_m;
  rpi_sel_t sel_o, sel_seen;
  logic io_seen;
  logic [7:0] ras_cnt, ras_d;
  logic [3:0][7:0] cas_cnt;
  int error_cnt = 0, tests_run = 0, cyc = 0, lat;
  rpi_row_t rows [15] = '{
    '{24'h00_0000, 1'b0, 16'h0000, 14'h2000, 4'h0}, '{24'h3F_FFFF, 1'b0, 16'h0000, 14'h2000, 4'h0},
    '{24'h80_0001, 1'b1, 16'h0001, 14'h0100, 4'h0}, '{24'h80_0002, 1'b1, 16'h0000, 14'h0080, 4'h0},
    '{24'h80_0004, 1'b0, 16'h0000, 14'h0040, 4'h0}, '{24'hA0_0001, 1'b1, 16'h0003, 14'h0004, 4'h0},
    '{24'hA0_0002, 1'b1, 16'h0003, 14'h0008, 4'h0}, '{24'hA0_0004, 1'b1, 16'h0003, 14'h0010, 4'h0},
    '{24'hA0_0008, 1'b1, 16'h0003, 14'h0020, 4'h0}, '{24'hA0_000F, 1'b1, 16'h0006, 14'h003C, 4'h0},
    '{24'hC0_0000, 1'b0, 16'h0000, 14'h0002, 4'h0}, '{24'h40_0000, 1'b0, 16'h0000, 14'h0200, 4'h1},
    '{24'h41_0000, 1'b1, 16'h1234, 14'h0400, 4'h2}, '{24'h42_FFFF, 1'b0, 16'h0000, 14'h0800, 4'h4},
    '{24'h43_FFFF, 1'b1, 16'hABCD, 14'h1000, 4'h8}};

  always #25 sys_clk_i = ~sys_clk_i;

  rpi_plane_interface dut (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i), .req_i(req_i),
    .req_valid_i(req_valid_i), .cpu_data_i(cpu_data_i), .src_plane_i(src_plane_i),
    .ready_o(ready_o), .ras_n_o(ras_n_o), .row_col_o(row_col_o), .cas_n_o(cas_n_o),
    .wr_n_o(wr_n_o), .oe_n_o(oe_n_o), .xcv_dir_in_o(xcv_dir_in_o), .xcv_en_n_o(xcv_en_n_o),
    .plane_xcv_en_n_o(plane_xcv_en_n_o), .io_en_o(io_en_o), .sel_o(sel_o),
    .plane_en_o(plane_en_o));
  rpi_plane_mem_model mem (.sys_clk_i(sys_clk_i), .ras_n_i(ras_n_o), .cas_n_i(cas_n_o),
    .ras_cnt_o(ras_cnt), .cas_cnt_o(cas_cnt));

  // ======================================================================
  // checking and closing
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  task automatic close_out();
    $display("checks %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : close_out

  // one access; the request is held until ready is seen, strobe cycles tallied
  task automatic do_acc(input logic [23:0] a, input logic w, input logic d, input logic s,
                        input logic [15:0] v, input logic [3:0] sp);
    logic [7:0] r0;
    logic [3:0][7:0] c0;
    logic mem, wr_sn, oe_sn, xcv_sn, dir_sn;
    logic [3:0] pxcv_sn;
    int rc_n;
    @(posedge sys_clk_i);
    r0 = ras_cnt;
    c0 = cas_cnt;
    lat = 0;
    mem = (a >= PLANE_BASE && a <= PLANE_LAST) || d;
    wr_sn = 1'b0;
    oe_sn = 1'b0;
    xcv_sn = 1'b0;
    dir_sn = 1'bx;
    pxcv_sn = 4'h0;
    rc_n = 0;
    req_i <= '{addr: a, wr: w, drawing: d, src_read: s};
    cpu_data_i <= v;
    src_plane_i <= sp;
    req_valid_i <= 1'b1;
    do begin
      @(negedge sys_clk_i);
      lat++;
      // strobes are tallied in every cycle of the access, ready cycle included
      if (wr_n_o === 1'b0) wr_sn = 1'b1;
      if (oe_n_o === 1'b0) oe_sn = 1'b1;
      if (xcv_en_n_o === 1'b0) begin
        xcv_sn = 1'b1;
        dir_sn = xcv_dir_in_o;
      end
      if (row_col_o === 1'b1) rc_n++;
      pxcv_sn = pxcv_sn | ~plane_xcv_en_n_o;
    end while (ready_o !== 1'b1 && lat < 20);
    chk("ready", ready_o, 1'b1);
    chk("acc_latency", lat, mem ? 1 + RAS_LOW_CYC + RAS_PRE_CYC : 2);
    chk("wr_strobe", wr_sn, w);
    chk("oe_strobe", oe_sn, !w);
    chk("xcv_en", xcv_sn, !d);
    if (!d) chk("xcv_dir", dir_sn, !w);
    chk("row_col", rc_n, mem ? CAS_LOW_CYC : 0);
    chk("src_xcv", pxcv_sn, (d && s) ? sp : 4'h0);
    sel_seen = sel_o;
    io_seen = io_en_o;
    ras_d = ras_cnt - r0;
    for (int p = 0; p < 4; p++) cas_m[p] = (cas_cnt[p] != c0[p]);
    for (int p = 0; p < 4; p++) if (cas_m[p]) chk("cas_len", cas_cnt[p] - c0[p], 2);
    @(posedge sys_clk_i);
    req_valid_i <= 1'b0;
  endtask : do_acc

  // a hang is cut short well past the hundred or so cycles the run needs
  always @(posedge sys_clk_i) begin
    cyc++;
    if (cyc == 4000) begin
      error_cnt++;
      close_out();
    end
  end

  // ======================================================================
  // main sequence: table of decode cases, then drawing and reset cases
  initial begin
    repeat (16) @(posedge sys_clk_i);
    sys_rst_i <= 1'b0;
    @(negedge sys_clk_i);
    chk("rst_plane_en", plane_en_o, PLANE_EN_RST);
    chk("rst_ras", ras_n_o, 1'b1);
    foreach (rows[i]) begin
      do_acc(rows[i].addr, rows[i].wr, 1'b0, 1'b0, rows[i].dat, 4'h0);
      chk("sel", sel_seen, rows[i].sel);
      chk("io_en", io_seen, rows[i].cas == 4'h0);
      chk("ras_len", ras_d, (rows[i].cas != 4'h0) ? 3 : 0);
      chk("cas_mask", cas_m, rows[i].cas);
      if (rows[i].cas == 4'h0) chk("latency", lat, 2);
    end
    do_acc(PCTL_BASE, 1'b1, 1'b0, 1'b0, 16'h0005, 4'h0);
    @(negedge sys_clk_i);
    chk("plane_en", plane_en_o, 4'h5);
    do_acc(24'h40_0010, 1'b0, 1'b1, 1'b0, 16'h0000, 4'h0);
    chk("draw_cas", cas_m, 4'h5);
    chk("draw_io", io_seen, 1'b0);
    do_acc(24'h41_0010, 1'b0, 1'b1, 1'b1, 16'h0000, 4'h8);
    chk("src_cas", cas_m, 4'h8);
    do_acc(24'h41_0010, 1'b1, 1'b1, 1'b0, 16'h0000, 4'h8);
    chk("dst_cas", cas_m, 4'h5);
    @(posedge sys_clk_i);
    sys_rst_i <= 1'b1;
    repeat (2) @(posedge sys_clk_i);
    sys_rst_i <= 1'b0;
    @(negedge sys_clk_i);
    chk("rerst_plane_en", plane_en_o, PLANE_EN_RST);
    chk("rerst_ready", ready_o, 1'b0);
    close_out();
  end
endmodule : raster_processor_plane_interface_test
